//--- bench/tc_line_src.sv
// stand-in for an external signal that feeds one flexible line
`timescale 1ns/1ps
`default_nettype none
module tc_line_src (
  input  wire logic       clk_i,  // system clock
  input  wire logic       run_i,  // wave runs while high
  input  wire logic [7:0] hi_i,   // high cycles per period
  input  wire logic [7:0] lo_i,   // low cycles per period
  output logic            lvl_o   // level onto the line
);
  logic [8:0] cnt;  // position in the period
  // low part comes first, so a burst of k whole periods gives exactly k rising edges
  always_ff @(posedge clk_i) begin
    if (!run_i) begin
      cnt   <= 9'h000;
      lvl_o <= 1'b0;  // idles low like a pulled-down input
    end else begin
      lvl_o <= (cnt >= 9'(lo_i));
      cnt   <= (cnt == 9'(hi_i) + 9'(lo_i) - 9'h001) ? 9'h000 : cnt + 9'h001;
    end
  end
endmodule
`default_nettype wire

//--- bench/tc_unit_tb_top.sv
// self-checking bench of the timer and counter unit
`timescale 1ns/1ps
`default_nettype none
module tc_unit_tb_top;
  logic                         clk_i = 1'b0;   // system clock
  logic                         rst_i = 1'b1;   // synchronous reset
  logic                         cyc_i = 1'b0;   // bus cycle
  logic                         stb_i = 1'b0;   // bus strobe
  logic                         we_i = 1'b0;    // bus write
  logic [7:0]                   adr_i = 8'h00;  // bus address
  logic [31:0]                  dat_i = 32'h0;  // bus write data
  logic                         ack_o;          // bus answer
  logic [31:0]                  dat_o;          // bus read data
  logic [tc_pkg::NUM_LINES-1:0] line_i;         // line levels
  logic [tc_pkg::NUM_LINES-1:0] line_o;         // line drive levels
  logic [tc_pkg::NUM_LINES-1:0] line_oe;        // line drive enables
  logic                         run = 1'b0;     // partner wave on
  logic [7:0]                   hi_len = 8'h03; // partner high cycles
  logic [7:0]                   lo_len = 8'h03; // partner low cycles
  logic                         lvl;            // partner level
  int                           src_line = 0;   // line the partner feeds
  int                           error_cnt = 0;  // mismatches
  int                           checks_done = 0; // comparisons made
  int                           seed = 65;      // random seed
  logic [31:0]                  q;              // last read data
  int                           pw_div[3] = '{0, 3, 2};             // 0 stands for undivided
  int                           pw_val[3] = '{49152, 32768, 16384}; // pwm values
  int                           pw_hi[3] = '{64, 384, 384};         // high clocks per period

  always #4 clk_i = ~clk_i;  // 125 MHz
  // only the fed line moves, the others sit low
  always_comb begin
    line_i = '0;
    line_i[src_line] = lvl;
  end

  tc_unit uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
    .line_i(line_i), .line_o(line_o), .line_oe(line_oe));
  tc_line_src src (.clk_i(clk_i), .run_i(run), .hi_i(hi_len), .lo_i(lo_len), .lvl_o(lvl));

  // ends the run with the verdict
  task automatic give_verdict;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; held until ack is sampled, so the slave may answer late
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // no cycle count is assumed; only the watchdog ends a wait that never answers
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // k whole periods on one line, then time for sync and capture
  task automatic wave(input int ln, input int k);
    @(posedge clk_i);
    src_line <= ln;
    @(posedge clk_i);
    run <= 1'b1;
    repeat (k * (hi_len + lo_len)) @(posedge clk_i);
    run <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // settle one period, then count high clocks over the next
  task automatic pwm_cnt(input int ln, input int p, input int e);
    int h;
    h = 0;
    repeat (p) @(posedge clk_i);
    repeat (p) begin
      @(posedge clk_i);
      if (line_o[ln] === 1'b1) h++;
    end
    chk(32'(h), 32'(e));
  endtask
  // expected line map from the allocation order
  function automatic logic [31:0] map_exp(int t, int f, int s, int c);
    int nx;
    logic [31:0] m;
    m = 32'hFFFF_FFFF;
    nx = f + t;
    if (t > 0) m[7:0] = 8'(f);
    if (t > 1) m[15:8] = 8'(f + 1);
    if (c[0] && s == 0) begin
      m[23:16] = 8'(nx);
      nx++;
    end
    if (c[1]) m[31:24] = 8'(nx);
    return m;
  endfunction

  // hang guard, far beyond the few thousand clocks the sequence needs
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    give_verdict;
  end

  // main sequence
  initial begin
    int t;
    int f;
    int s;
    int c;
    int cf;
    int k;
    cf = 4;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(tc_pkg::OFS_CONFIG, 32'h0000_0040);
    rd(tc_pkg::OFS_LINE_MAP, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    // every timer count, source and enable set; first line 9 must be refused
    for (int i = 0; i < 32; i++) begin
      t = i % 4;
      s = (i / 4) % 2;
      c = i / 8;
      f = 4 + ($unsigned($random(seed)) % 6);
      if (f <= 8) cf = f;
      wb(1'b1, tc_pkg::OFS_CONFIG, 32'(t) | 32'(f) << 4 | 32'(s) << 8);
      wb(1'b1, tc_pkg::OFS_CNT_EN, 32'(c));
      if (t > 2) t = 2;
      rd(tc_pkg::OFS_CONFIG, 32'(t) | 32'(cf) << 4 | 32'(s) << 8);
      rd(tc_pkg::OFS_LINE_MAP, map_exp(t, cf, s, c));
      chk(32'(line_oe), 32'((1 << t) - 1) << cf);
    end
    // counters on lines 4 and 5
    wb(1'b1, tc_pkg::OFS_CONFIG, 32'h0000_0040);
    wb(1'b1, tc_pkg::OFS_CNT_EN, 32'h0000_0003);
    k = 1 + ($unsigned($random(seed)) % 8);
    wave(5, k);
    rd(tc_pkg::OFS_COUNT1, 32'(k));
    rd(tc_pkg::OFS_COUNT0, 32'h0);
    wb(1'b1, tc_pkg::OFS_COUNT1, 32'h0);
    chk(q, 32'(k));
    rd(tc_pkg::OFS_COUNT1, 32'h0);
    wave(4, 2);
    rd(tc_pkg::OFS_COUNT0, 32'h2);
    wb(1'b1, tc_pkg::OFS_CNT_EN, 32'h0000_0103);
    rd(tc_pkg::OFS_COUNT0, 32'h0);
    // divided source: counter 0 stops, counter 1 moves down to line 4
    wb(1'b1, tc_pkg::OFS_CONFIG, 32'h0003_0140);
    wave(4, 3);
    rd(tc_pkg::OFS_COUNT0, 32'h0);
    rd(tc_pkg::OFS_COUNT1, 32'h3);
    // timer 1 measures duty on line 5 while timer 0 drives line 4
    wb(1'b1, tc_pkg::OFS_CONFIG, 32'h0000_0042);
    wb(1'b1, tc_pkg::OFS_TMR_MODE, 32'h0000_0002);
    hi_len <= 8'h0A;
    lo_len <= 8'h14;
    wave(5, 3);
    rd(tc_pkg::OFS_TMR_VAL1, 32'h0014_000A);
    chk(32'(line_oe), 32'h0000_0010);
    hi_len <= 8'h05;
    wave(5, 3);
    rd(tc_pkg::OFS_TMR_VAL1, 32'h0014_0005);
    wb(1'b1, tc_pkg::OFS_TMR_VAL1, 32'h0);
    rd(tc_pkg::OFS_TMR_VAL1, 32'h0);
    // pwm on line 7 over sources and dividers
    wb(1'b1, tc_pkg::OFS_TMR_MODE, 32'h0);
    for (int j = 0; j < 3; j++) begin
      wb(1'b1, tc_pkg::OFS_CONFIG, 32'(pw_div[j]) << 16 | 32'(pw_div[j] != 0) << 8 | 32'h71);
      wb(1'b1, tc_pkg::OFS_TMR_VAL0, 32'(pw_val[j]));
      rd(tc_pkg::OFS_TMR_VAL0, 32'(pw_val[j]));
      pwm_cnt(7, 256 * (pw_div[j] == 0 ? 1 : pw_div[j]), pw_hi[j]);
    end
    // pin configuration reset brings back the default setup
    wb(1'b1, tc_pkg::OFS_CONFIG, 32'h8000_0000);
    rd(tc_pkg::OFS_CONFIG, 32'h0000_0040);
    rd(tc_pkg::OFS_LINE_MAP, 32'hFFFF_FFFF);
    rd(tc_pkg::OFS_CNT_EN, 32'h0);
    chk(32'(line_oe), 32'h0);
    give_verdict;
  end
endmodule
`default_nettype wire

//--- common/tc_pkg.sv
// constants, register map and state types of the timer and counter unit
package tc_pkg;
  localparam int unsigned NUM_LINES    = 16;          // flexible lines served
  localparam int unsigned NUM_TIMERS   = 2;           // timers available
  localparam int unsigned NUM_COUNTERS = 2;           // edge counters available
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG    = 8'h00;       // timers, first line, clock
  localparam logic [7:0] OFS_CNT_EN    = 8'h04;       // counter enables
  localparam logic [7:0] OFS_TMR_MODE  = 8'h08;       // timer modes
  localparam logic [7:0] OFS_TMR_VAL0  = 8'h0C;       // timer 0 value
  localparam logic [7:0] OFS_TMR_VAL1  = 8'h10;       // timer 1 value
  localparam logic [7:0] OFS_COUNT0    = 8'h14;       // counter 0 count
  localparam logic [7:0] OFS_COUNT1    = 8'h18;       // counter 1 count
  localparam logic [7:0] OFS_LINE_MAP  = 8'h1C;       // line of each resource
  // config field positions
  localparam int unsigned POS_TMR_NUM  = 0;           // [1:0] timers enabled
  localparam int unsigned POS_FIRST    = 4;           // [7:4] first timer line
  localparam int unsigned POS_SRC      = 8;           // clock source select
  localparam int unsigned POS_DIV      = 16;          // [23:16] divider
  localparam int unsigned POS_PINRST   = 31;          // write 1: pin config reset
  localparam int unsigned POS_CLEAR    = 8;           // counter clear bits in CNT_EN
  // values after reset and config limits
  localparam logic [1:0] RST_TMR_NUM   = 2'h0;
  localparam logic [3:0] RST_FIRST     = 4'h4;
  localparam logic [3:0] MIN_FIRST     = 4'h4;
  localparam logic [3:0] MAX_FIRST     = 4'h8;
  localparam logic [1:0] MAX_TMR_NUM   = 2'h2;
  localparam logic [7:0] RST_DIV       = 8'h00;
  localparam logic [7:0] NO_LINE       = 8'hFF;       // map code: not assigned
  typedef enum logic {undivided_fast_clock_source, divided_fast_clock_source} clk_src_t;
  typedef enum logic {pwm_eight_bit_mode, duty_cycle_input_mode} tmr_mode_t;
  // whole state of the top block
  typedef struct packed {
    logic [1:0]                  timer_count_setting;  // timers enabled
    logic [3:0]                  first_timer_line;     // line of first timer
    clk_src_t                    timer_clock_source;   // shared clock source
    logic [7:0]                  timer_clock_divider;  // 0 means 256
    logic [1:0]                  cnt_en;               // counter enables
    logic [1:0]                  tmr_mode;             // per-timer mode bit
    logic [1:0][15:0]            tval;                 // timer values
    logic [1:0]                  meas_clr;             // measurement clear pulses
    logic [1:0][31:0]            count;                // edge counts
    logic [NUM_LINES-1:0]        sync1;                // first sync stage
    logic [NUM_LINES-1:0]        sync2;                // second sync stage
    logic [NUM_LINES-1:0]        prev;                 // last synced level
    logic [7:0]                  div_cnt;              // timer clock divider count
    logic                        tick;                 // timer clock enable
    logic                        ack;                  // bus answer
    logic [31:0]                 dat;                  // bus read data
    logic [NUM_LINES-1:0]        line_out;             // line output levels
    logic [NUM_LINES-1:0]        line_oe;              // line drive enables
  } top_st_t;
  // state of one timer channel
  typedef struct packed {
    logic [7:0]  phase;     // pwm phase
    logic        pwm;       // pwm output
    logic        last;      // last input level
    logic [15:0] hi;        // high ticks so far
    logic [15:0] lo;        // low ticks so far
    logic [15:0] hi_hold;   // high time of current period
    logic [31:0] meas;      // {low, high}
  } chan_st_t;
endpackage

//--- rtl/tc_timer_chan.sv
// one timer: 8-bit pwm output or duty-cycle measurement input
`timescale 1ns/1ps
`default_nettype none
module tc_timer_chan (
  input  wire logic        clk_i,    // system clock
  input  wire logic        rst_i,    // synchronous reset
  input  wire logic        tick_i,   // shared timer clock enable
  input  wire logic        run_i,    // timer enabled
  input  wire logic        mode_i,   // 0 pwm, 1 duty input
  input  wire logic [15:0] value_i,  // timer value
  input  wire logic        clear_i,  // clear measurement
  input  wire logic        level_i,  // synced input level
  output logic             pwm_o,    // pwm level
  output logic [31:0]      meas_o    // {low, high} measurement
);
  tc_pkg::chan_st_t st;       // registered state
  tc_pkg::chan_st_t next_st;  // next state
  logic rise;                 // input rising edge
  logic fall;                 // input falling edge

  assign pwm_o  = st.pwm;
  assign meas_o = st.meas;
  assign rise   = level_i & ~st.last;
  assign fall   = ~level_i & st.last;

  // next state of pwm and measurement
  always_comb begin
    next_st      = st;
    next_st.last = level_i;
    if (!run_i) begin
      next_st.phase = 8'h00;
      next_st.pwm   = 1'b0;
      next_st.hi    = 16'h0000;
      next_st.lo    = 16'h0000;
    end else if (mode_i == 1'b0) begin
      // period is 256 ticks; high while phase at or above the top byte
      if (tick_i) begin
        next_st.phase = st.phase + 8'h01;
        next_st.pwm   = (next_st.phase >= value_i[15:8]);
      end
    end else begin
      if (clear_i) begin
        next_st.meas = 32'h0000_0000;  // writing zero drops the old result
      end
      // counts saturate so a stuck line reads as full scale, not wrapped
      if (tick_i && level_i && st.hi != 16'hFFFF) begin
        next_st.hi = st.hi + 16'h0001;
      end
      if (tick_i && !level_i && st.lo != 16'hFFFF) begin
        next_st.lo = st.lo + 16'h0001;
      end
      // the edge cycle itself is the first cycle of the new level, so it counts
      if (fall) begin
        next_st.hi_hold = st.hi;
        next_st.lo      = {15'h0000, tick_i};
      end
      if (rise) begin
        next_st.meas = {st.lo, st.hi_hold};  // low in upper half
        next_st.hi   = {15'h0000, tick_i};
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_pwm_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && !mode_i && tick_i && st.phase == 8'hFF |=> st.phase == 8'h00)
    else $error("pwm phase did not wrap after 256 ticks");
  a_meas_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    run_i && mode_i && clear_i && !rise |=> meas_o == 32'h0000_0000)
    else $error("duty measurement not cleared");
endmodule
`default_nettype wire

//--- rtl/tc_unit.sv
// timer and counter unit with a classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module tc_unit (
  input  wire logic                         clk_i,   // 125 MHz system clock
  input  wire logic                         rst_i,   // synchronous reset
  input  wire logic                         cyc_i,   // wishbone cycle
  input  wire logic                         stb_i,   // wishbone strobe
  input  wire logic                         we_i,    // wishbone write
  input  wire logic [7:0]                   adr_i,   // wishbone byte address
  input  wire logic [3:0]                   sel_i,   // wishbone byte enables
  input  wire logic [31:0]                  dat_i,   // wishbone write data
  output logic                              ack_o,   // wishbone acknowledge
  output logic [31:0]                       dat_o,   // wishbone read data
  input  wire logic [tc_pkg::NUM_LINES-1:0] line_i,  // flexible line levels
  output logic      [tc_pkg::NUM_LINES-1:0] line_o,  // flexible line drive level
  output logic      [tc_pkg::NUM_LINES-1:0] line_oe  // flexible line drive enable
);
  tc_pkg::top_st_t st;              // registered state
  tc_pkg::top_st_t next_st;         // next state
  logic        req;                 // new bus request this cycle
  logic        wr;                  // write taken this cycle
  logic [31:0] wmask;               // byte lanes as a bit mask
  logic [31:0] rdata;               // read mux
  logic [1:0][3:0] tline;           // line of each timer
  logic [1:0][3:0] cline;           // line of each counter
  logic [1:0]  t_on;                // timer active
  logic [1:0]  c_on;                // counter active
  logic [1:0]  pwm;                 // channel pwm levels
  logic [1:0][31:0] meas;           // channel measurements
  logic [1:0]  t_lvl;               // synced input on each timer line
  logic [1:0]  cnt_wr;              // write to a count register
  logic [7:0]  div_last;            // terminal divider count
  logic [31:0] cfg_w;               // merged config write
  logic [3:0]  first_w;             // requested first line

  assign ack_o   = st.ack;
  assign dat_o   = st.dat;
  assign line_o  = st.line_out;
  assign line_oe = st.line_oe;
  assign req     = cyc_i & stb_i & ~st.ack;
  assign wr      = req & we_i;
  assign wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign cnt_wr  = {wr && adr_i == tc_pkg::OFS_COUNT1, wr && adr_i == tc_pkg::OFS_COUNT0};
  // 0 - 1 wraps to 255, so a zero setting gives a 256-tick period
  assign div_last = st.timer_clock_divider - 8'h01;
  assign cfg_w = (32'({st.timer_clock_divider, 7'h00, st.timer_clock_source,
                       st.first_timer_line, 2'h0, st.timer_count_setting}) & ~wmask)
                 | (dat_i & wmask);
  assign first_w = cfg_w[tc_pkg::POS_FIRST +: 4];

  // line assignment: timers first, then counters in order
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      tline[k] = st.first_timer_line + 4'(k);
      t_on[k]  = (2'(k) < st.timer_count_setting);
    end
    // counter 0 is lost to the divided source
    c_on[0]  = st.cnt_en[0] &&
               (st.timer_clock_source == tc_pkg::undivided_fast_clock_source);
    c_on[1]  = st.cnt_en[1];
    cline[0] = st.first_timer_line + 4'(st.timer_count_setting);
    cline[1] = cline[0] + 4'(c_on[0]);
    for (int k = 0; k < 2; k++) begin
      t_lvl[k] = st.sync2[tline[k]];
    end
  end

  // the two timers share the tick and differ only in settings
  for (genvar g = 0; g < tc_pkg::NUM_TIMERS; g++) begin : g_tmr
    tc_timer_chan u_chan (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .tick_i  (st.tick),
      .run_i   (t_on[g]),
      .mode_i  (st.tmr_mode[g]),
      .value_i (st.tval[g]),
      .clear_i (st.meas_clr[g]),
      .level_i (t_lvl[g]),
      .pwm_o   (pwm[g]),
      .meas_o  (meas[g])
    );
  end

  // read mux; timer value reads show the measurement in duty mode
  always_comb begin
    rdata = 32'h0000_0000;
    if (adr_i == tc_pkg::OFS_CONFIG) begin
      rdata = 32'({st.timer_clock_divider, 7'h00, st.timer_clock_source,
                   st.first_timer_line, 2'h0, st.timer_count_setting});
    end else if (adr_i == tc_pkg::OFS_CNT_EN) begin
      rdata = 32'(st.cnt_en);
    end else if (adr_i == tc_pkg::OFS_TMR_MODE) begin
      rdata = 32'(st.tmr_mode);
    end else if (adr_i == tc_pkg::OFS_TMR_VAL0) begin
      rdata = st.tmr_mode[0] ? meas[0] : 32'(st.tval[0]);
    end else if (adr_i == tc_pkg::OFS_TMR_VAL1) begin
      rdata = st.tmr_mode[1] ? meas[1] : 32'(st.tval[1]);
    end else if (adr_i == tc_pkg::OFS_COUNT0) begin
      rdata = st.count[0];
    end else if (adr_i == tc_pkg::OFS_COUNT1) begin
      rdata = st.count[1];
    end else if (adr_i == tc_pkg::OFS_LINE_MAP) begin
      rdata = {c_on[1] ? 8'(cline[1]) : tc_pkg::NO_LINE,
               c_on[0] ? 8'(cline[0]) : tc_pkg::NO_LINE,
               t_on[1] ? 8'(tline[1]) : tc_pkg::NO_LINE,
               t_on[0] ? 8'(tline[0]) : tc_pkg::NO_LINE};
    end
  end

  // next state: bus, synchronisers, divider, counters, line drivers
  always_comb begin
    next_st          = st;
    next_st.sync1    = line_i;
    next_st.sync2    = st.sync1;
    next_st.prev     = st.sync2;
    next_st.meas_clr = 2'b00;
    // bus answers one cycle after the request, ack lasts one cycle
    next_st.ack = req;
    // a write answers with the value held before it, so read-and-clear is safe
    if (req) begin
      next_st.dat = rdata;
    end
    // one base tick per clock; divided source counts them up from 0 to div_last
    if (st.timer_clock_source == tc_pkg::divided_fast_clock_source) begin
      // at or past the end: a smaller divider written mid-count must not stall the clock
      next_st.tick    = (st.div_cnt >= div_last);
      next_st.div_cnt = next_st.tick ? 8'h00 : st.div_cnt + 8'h01;
    end else begin
      next_st.tick    = 1'b1;
      next_st.div_cnt = 8'h00;
    end
    // edges on active counter lines; a clear in the same cycle keeps the edge
    for (int k = 0; k < 2; k++) begin
      if (cnt_wr[k] || (wr && adr_i == tc_pkg::OFS_CNT_EN && sel_i[1] &&
                        dat_i[tc_pkg::POS_CLEAR + k])) begin
        next_st.count[k] = 32'h0000_0000;  // counter_clear_request
      end
      if (c_on[k] && st.sync2[cline[k]] && !st.prev[cline[k]]) begin
        next_st.count[k] = next_st.count[k] + 32'h0000_0001;
      end
    end
    // register writes
    if (wr && adr_i == tc_pkg::OFS_CONFIG) begin
      if (sel_i[3] && dat_i[tc_pkg::POS_PINRST]) begin
        // pin_configuration_reset: back to the power-up setup
        next_st.timer_count_setting = tc_pkg::RST_TMR_NUM;
        next_st.first_timer_line    = tc_pkg::RST_FIRST;
        next_st.timer_clock_source  = tc_pkg::undivided_fast_clock_source;
        next_st.timer_clock_divider = tc_pkg::RST_DIV;
        next_st.cnt_en              = 2'b00;
      end else begin
        // more than two timers is clamped rather than refused
        next_st.timer_count_setting = (cfg_w[1:0] > tc_pkg::MAX_TMR_NUM) ?
                                      tc_pkg::MAX_TMR_NUM : cfg_w[1:0];
        // an out-of-range first line leaves the old one in place
        if (first_w >= tc_pkg::MIN_FIRST && first_w <= tc_pkg::MAX_FIRST) begin
          next_st.first_timer_line = first_w;
        end
        next_st.timer_clock_source  = tc_pkg::clk_src_t'(cfg_w[tc_pkg::POS_SRC]);
        next_st.timer_clock_divider = cfg_w[tc_pkg::POS_DIV +: 8];
      end
    end else if (wr && adr_i == tc_pkg::OFS_CNT_EN && sel_i[0]) begin
      next_st.cnt_en = dat_i[1:0];  // counter_enable_request
    end else if (wr && adr_i == tc_pkg::OFS_TMR_MODE && sel_i[0]) begin
      next_st.tmr_mode = dat_i[1:0];
    end else if (wr && (adr_i == tc_pkg::OFS_TMR_VAL0 || adr_i == tc_pkg::OFS_TMR_VAL1)) begin
      // timer_value_write; zero into a duty timer clears its result
      next_st.tval[adr_i[4]] = (st.tval[adr_i[4]] & ~wmask[15:0])
                               | (dat_i[15:0] & wmask[15:0]);
      next_st.meas_clr[adr_i[4]] = (dat_i[15:0] & wmask[15:0]) == 16'h0000;
    end
    // only pwm timers drive their line; all else stays an input
    next_st.line_out = '0;
    next_st.line_oe  = '0;
    for (int k = 0; k < 2; k++) begin
      if (t_on[k] && st.tmr_mode[k] == 1'b0) begin
        next_st.line_out[tline[k]] = pwm[k];
        next_st.line_oe[tline[k]]  = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st                     <= '0;
      st.first_timer_line    <= tc_pkg::RST_FIRST;
      st.timer_clock_divider <= tc_pkg::RST_DIV;
    end else begin
      st <= next_st;
    end
  end

  a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o ##1 !ack_o)
    else $error("bus answer not one cycle long");
  a_pin_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == tc_pkg::OFS_CONFIG && sel_i[3] && dat_i[31] |=>
      st.timer_count_setting == 2'h0 && st.first_timer_line == 4'h4 &&
      st.timer_clock_divider == 8'h00 && st.cnt_en == 2'b00 &&
      st.timer_clock_source == tc_pkg::undivided_fast_clock_source)
    else $error("pin configuration reset incomplete");
  a_tick_undiv: assert property (@(posedge clk_i) disable iff (rst_i)
    st.timer_clock_source == tc_pkg::undivided_fast_clock_source |=> st.tick)
    else $error("undivided source missed a timer tick");
  a_cnt_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_wr[0] |=> st.count[0] <= 32'h0000_0001)
    else $error("counter 0 not cleared by its clear request");
  a_first_range: assert property (@(posedge clk_i) disable iff (rst_i)
    st.first_timer_line >= 4'h4 && st.first_timer_line <= 4'h8)
    else $error("first timer line out of range");
  a_div_two: assert property (@(posedge clk_i) disable iff (rst_i)
    st.timer_clock_source == tc_pkg::divided_fast_clock_source &&
    st.timer_clock_divider == 8'h02 && $stable(st.timer_clock_divider) && st.tick
    && !wr |=> !st.tick ##1 st.tick)
    else $error("divider two does not give every other tick");
  a_cnt0_off: assert property (@(posedge clk_i) disable iff (rst_i)
    st.timer_clock_source == tc_pkg::divided_fast_clock_source && !cnt_wr[0] &&
    !(wr && adr_i == tc_pkg::OFS_CNT_EN) |=> st.count[0] == $past(st.count[0]))
    else $error("counter 0 moved with divided clock source");
  a_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_wr[1] |=> ack_o && dat_o == $past(st.count[1]) && st.count[1] <= 32'h1)
    else $error("read-and-clear returned wrong value");
endmodule
`default_nettype wire
